// file: inc/light_ctrl_pkg.sv
// Shared constants and types for the light controller output stage.
package light_ctrl_pkg;
    localparam int          CLK_HZ          = 10000000;
    localparam int          MS_PER_TENTH    = 100;
    localparam int          CYC_PER_TENTH   = CLK_HZ / 1000 * MS_PER_TENTH;
    localparam logic [7:0]  SYNC_DEFAULT    = 8'hC8;
    localparam logic [6:0]  HYST_DEFAULT    = 7'h14;
    localparam logic [6:0]  HYST_MAX        = 7'h5A;
    localparam logic [7:0]  PCT_UNITY       = 8'h64;
    localparam logic [5:0]  REP_SEC_MAX     = 6'h3B;
    localparam logic [5:0]  WAIT_SEC_MIN    = 6'h01;
    localparam logic [3:0]  TENTHS_PER_SEC  = 4'hA;
    localparam logic [3:0]  DIM_UP_STOP     = 4'h8;

    typedef enum logic [1:0] {
        OFS_FIXED = 2'b00,
        OFS_INC   = 2'b01,
        OFS_DEC   = 2'b10
    } ofs_mode_t;

    typedef enum logic [1:0] {
        SU_SWITCH   = 2'b00,
        SU_RELATIVE = 2'b01,
        SU_ABSOLUTE = 2'b10,
        SU_ADAPTIVE = 2'b11
    } su_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_DIM   = 3'b010,
        ST_WAIT  = 3'b011,
        ST_MAIN  = 3'b100
    } phase_t;
endpackage

// file: inc/chan_cfg_if.sv
// Offset configuration and result of one derived channel.
`timescale 1ns/100ps
interface chan_cfg_if;
    import light_ctrl_pkg::*;
    ofs_mode_t   mode;
    logic [7:0]  base;
    logic [7:0]  offset;
    logic [7:0]  percent;
    logic [7:0]  sync_level;
    logic [6:0]  hyst;
    logic [7:0]  value;
    modport calc (input mode, base, offset, percent, sync_level, hyst, output value);
    modport ctrl (output mode, base, offset, percent, sync_level, hyst, input value);
endinterface

// file: rtl/chan_offset.sv
// Derives one lighting channel from the channel one output.
`timescale 1ns/100ps
module chan_offset
    import light_ctrl_pkg::*;
(
    input  wire logic   sys_clk_i,
    input  wire logic   nrst_i,
    chan_cfg_if.calc    cfg
);
    logic              on_q;
    logic signed [9:0] eff_ofs;
    logic signed [9:0] sum;
    logic [15:0]       prod;
    logic [15:0]       scaled;
    logic [7:0]        span;
    logic [15:0]       ramp;
    logic [9:0]        thr;

    always_comb begin
        span = (cfg.sync_level > 8'h01) ? cfg.sync_level - 8'h01 : 8'h01;
        ramp = 16'($signed({{8{cfg.offset[7]}}, cfg.offset}) *
                   $signed({8'h00, cfg.sync_level - cfg.base}));
        eff_ofs = {{2{cfg.offset[7]}}, cfg.offset};
        if (cfg.mode == OFS_DEC) begin
            if (cfg.base >= cfg.sync_level) begin
                eff_ofs = 10'sh000;
            end else begin
                eff_ofs = 10'($signed(ramp) / $signed({8'h00, span}));
            end
        end
    end

    // negative-offset hysteresis threshold in channel one units
    always_comb begin
        thr = 10'h000;
        if (eff_ofs < 0) begin
            thr = 10'(-eff_ofs) + ((cfg.hyst > HYST_MAX) ? 10'(HYST_MAX) : 10'(cfg.hyst));
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            on_q <= 1'b0;
        end else if (eff_ofs >= 0) begin
            on_q <= 1'b1;
        end else if ({2'b00, cfg.base} > thr) begin
            on_q <= 1'b1;
        end else if ({2'b00, cfg.base} <= 10'(-eff_ofs)) begin
            on_q <= 1'b0;
        end
    end

    always_comb begin
        prod   = 16'(cfg.base) * 16'(cfg.percent);
        scaled = prod / 16'(PCT_UNITY);
        sum    = $signed({2'b00, cfg.base}) + eff_ofs;
    end

    always_comb begin
        if (cfg.mode == OFS_INC) begin
            cfg.value = (scaled > 16'h00FF) ? 8'hFF : scaled[7:0];
        end else if (cfg.base == 8'h00 || !on_q) begin
            cfg.value = 8'h00;
        end else if (sum < 0) begin
            cfg.value = 8'h00;
        end else if (sum > 10'sh0FF) begin
            cfg.value = 8'hFF;
        end else begin
            cfg.value = sum[7:0];
        end
    end
endmodule

// file: rtl/light_out_stage.sv
// Startup sequencing and three-channel output stage of the light controller.
`timescale 1ns/100ps
// Contract
// - Drive one to three lighting channels, count chosen by configuration.
// - With two or three channels, emit only absolute byte values.
// - Regulate channel one only; derive others by a chosen offset method.
// - Fixed mode adds a constant signed offset per channel.
// - Fixed and decreasing offsets start at one; zero input gives zero.
// - Increasing mode scales channel one by a percentage, saturating at 255.
// - Below 100 percent gives lower output, above gives higher.
// - Decreasing mode shrinks start offset to zero at the sync level.
// - Negative offsets use an on-off hysteresis up to 90, default 20.
// - Startup skips to main phase when brightness meets the setpoint.
// - Switch-on startup sends one switching telegram; single channel only.
// - Relative startup dims up cyclically, then sends stop; single channel.
// - Absolute startup sends one configured value when too dark.
// - Adaptive startup computes a byte value from brightness and range.
// - Relative startup uses a configured 3-bit step width code.
// - Dim telegrams optionally repeat every seconds plus tenths.
// - Wait a configured 1 to 59 seconds before the main phase; only the minimum is clamped, so up to 63 is taken.
module light_out_stage
    import light_ctrl_pkg::*;
#(
    parameter int LUX_W = 16
)(
    input  wire logic             sys_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [1:0]       chan_count_i,
    input  wire ofs_mode_t        ofs_mode_i,
    input  wire logic [7:0]       ofs2_i,
    input  wire logic [7:0]       ofs3_i,
    input  wire logic [7:0]       pct2_i,
    input  wire logic [7:0]       pct3_i,
    input  wire logic [7:0]       sync2_i,
    input  wire logic [7:0]       sync3_i,
    input  wire logic [6:0]       hyst_i,
    input  wire su_mode_t         su_mode_i,
    input  wire logic [2:0]       step_width_i,
    input  wire logic             rep_en_i,
    input  wire logic [5:0]       rep_sec_i,
    input  wire logic [3:0]       rep_tenth_i,
    input  wire logic [5:0]       wait_sec_i,
    input  wire logic [7:0]       su_value_i,
    input  wire logic [LUX_W-1:0] lux_range_i,
    input  wire logic             start_i,
    input  wire logic [LUX_W-1:0] lux_i,
    input  wire logic [LUX_W-1:0] setpoint_i,
    input  wire logic [7:0]       ch1_main_i,
    output logic                  main_phase_o,
    output logic                  switch_tx_o,
    output logic                  dim_tx_o,
    output logic [3:0]            dim_code_o,
    output logic                  value_tx_o,
    output logic [7:0]            ch1_o,
    output logic [7:0]            ch2_o,
    output logic [7:0]            ch3_o
);
    phase_t            state_q;
    logic [7:0]        ch1_q;
    logic [19:0]       div_q;
    logic              tick;
    logic [9:0]        tenth_q;
    logic [9:0]        rep_len;
    logic              multi;
    su_mode_t          su_eff;
    logic              dark;
    logic [LUX_W+7:0]  adapt_num;
    logic [7:0]        adapt_val;

    chan_cfg_if c2 ();
    chan_cfg_if c3 ();

    // channel one feeds both derived channels
    assign c2.mode       = ofs_mode_i;
    assign c2.base       = ch1_q;
    assign c2.offset     = ofs2_i;
    assign c2.percent    = pct2_i;
    assign c2.sync_level = sync2_i;
    assign c2.hyst       = hyst_i;
    assign c3.mode       = ofs_mode_i;
    assign c3.base       = ch1_q;
    assign c3.offset     = ofs3_i;
    assign c3.percent    = pct3_i;
    assign c3.sync_level = sync3_i;
    assign c3.hyst       = hyst_i;

    chan_offset u_ch2 (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .cfg       (c2)
    );
    chan_offset u_ch3 (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .cfg       (c3)
    );

    always_comb begin
        multi  = (chan_count_i >= 2'h2);
        su_eff = su_mode_i;
        if (multi && (su_mode_i == SU_SWITCH || su_mode_i == SU_RELATIVE)) begin
            su_eff = SU_ABSOLUTE;
        end
        dark = (lux_i < setpoint_i);
    end

    // adaptive value scales the missing brightness over the range
    always_comb begin
        adapt_num = (LUX_W+8)'(setpoint_i - lux_i) * (LUX_W+8)'(8'hFF);
        if (lux_range_i == '0) begin
            adapt_val = 8'hFF;
        end else if (adapt_num / (LUX_W+8)'(lux_range_i) > (LUX_W+8)'(8'hFF)) begin
            adapt_val = 8'hFF;
        end else begin
            adapt_val = 8'((adapt_num / (LUX_W+8)'(lux_range_i)));
        end
        if (adapt_val == 8'h00) begin
            adapt_val = 8'h01;
        end
    end

    // Tenth-second enable; all timing here is coarse so one divider serves.
    // Twenty bits hold the full tenth-second count without wrapping early.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= 20'h00000;
        end else if (div_q == 20'(CYC_PER_TENTH - 1)) begin
            div_q <= 20'h00000;
        end else begin
            div_q <= div_q + 20'h00001;
        end
    end
    assign tick = (div_q == 20'(CYC_PER_TENTH - 1));

    assign rep_len = 10'((rep_sec_i > REP_SEC_MAX ? REP_SEC_MAX : rep_sec_i))
                     * 10'(TENTHS_PER_SEC) + 10'(rep_tenth_i);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= ST_IDLE;
            tenth_q    <= 10'h000;
            switch_tx_o <= 1'b0;
            dim_tx_o   <= 1'b0;
            dim_code_o <= 4'h0;
            value_tx_o <= 1'b0;
            ch1_q      <= 8'h00;
        end else begin
            switch_tx_o <= 1'b0;
            dim_tx_o    <= 1'b0;
            value_tx_o  <= 1'b0;
            if (tick && tenth_q != 10'h000) begin
                tenth_q <= tenth_q - 10'h001;
            end
            unique case (state_q)
                ST_IDLE: begin
                    if (start_i) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (!dark) begin
                        state_q <= ST_MAIN;
                    end else begin
                        unique case (su_eff)
                            SU_SWITCH: switch_tx_o <= 1'b1;
                            SU_ABSOLUTE: begin
                                ch1_q      <= su_value_i;
                                value_tx_o <= 1'b1;
                            end
                            SU_ADAPTIVE: begin
                                ch1_q      <= adapt_val;
                                value_tx_o <= 1'b1;
                            end
                            SU_RELATIVE: begin
                                dim_tx_o   <= 1'b1;
                                dim_code_o <= DIM_UP_STOP | {1'b0, step_width_i};
                            end
                        endcase
                        tenth_q <= rep_len;
                        if (su_eff == SU_RELATIVE) begin
                            state_q <= ST_DIM;
                        end else begin
                            tenth_q <= 10'((wait_sec_i < WAIT_SEC_MIN ? WAIT_SEC_MIN
                                            : wait_sec_i)) * 10'(TENTHS_PER_SEC);
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_DIM: begin
                    if (!dark) begin
                        dim_tx_o   <= 1'b1;
                        dim_code_o <= DIM_UP_STOP;
                        tenth_q    <= 10'((wait_sec_i < WAIT_SEC_MIN ? WAIT_SEC_MIN
                                           : wait_sec_i)) * 10'(TENTHS_PER_SEC);
                        state_q    <= ST_WAIT;
                    end else if (rep_en_i && tick && tenth_q <= 10'h001) begin
                        dim_tx_o <= 1'b1;
                        tenth_q  <= rep_len;
                    end
                end
                ST_WAIT: begin
                    if (tick && tenth_q <= 10'h001) begin
                        state_q <= ST_MAIN;
                    end
                end
                ST_MAIN: begin
                    ch1_q <= ch1_main_i;
                    if (!start_i) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ch1_o        <= 8'h00;
            ch2_o        <= 8'h00;
            ch3_o        <= 8'h00;
            main_phase_o <= 1'b0;
        end else begin
            main_phase_o <= (state_q == ST_MAIN);
            ch1_o        <= ch1_q;
            ch2_o        <= (chan_count_i >= 2'h2) ? c2.value : 8'h00;
            ch3_o        <= (chan_count_i == 2'h3) ? c3.value : 8'h00;
        end
    end
endmodule

// file: tb/light_out_monitor.sv
// Port-level assertion checker for the light controller output stage.
`timescale 1ns/100ps
module light_out_monitor
    import light_ctrl_pkg::*;
#(
    parameter int LUX_W = 16
)(
    input wire logic             sys_clk_i,
    input wire logic             nrst_i,
    input wire logic [1:0]       chan_count_i,
    input wire ofs_mode_t        ofs_mode_i,
    input wire logic [7:0]       pct3_i,
    input wire logic [2:0]       step_width_i,
    input wire logic             start_i,
    input wire logic [LUX_W-1:0] lux_i,
    input wire logic [LUX_W-1:0] setpoint_i,
    input wire logic             main_phase_o,
    input wire logic             switch_tx_o,
    input wire logic             dim_tx_o,
    input wire logic [3:0]       dim_code_o,
    input wire logic             value_tx_o,
    input wire logic [7:0]       ch1_o,
    input wire logic [7:0]       ch2_o,
    input wire logic [7:0]       ch3_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_bright_main;
        $rose(start_i) ##1 (start_i && lux_i >= setpoint_i)[*3] |-> ##[0:2] main_phase_o;
    endproperty
    a_bright_main: assert property (p_bright_main) else $error("main phase missing");
    property p_bright_quiet;
        $rose(start_i) ##1 (lux_i >= setpoint_i) |-> ##1 !(switch_tx_o || dim_tx_o || value_tx_o);
    endproperty
    a_bright_quiet: assert property (p_bright_quiet) else $error("telegram when bright");
    property p_multi_no_switch;
        chan_count_i >= 2'h2 && $past(chan_count_i) >= 2'h2 |-> !switch_tx_o;
    endproperty
    a_multi_no_switch: assert property (p_multi_no_switch) else $error("switch telegram");
    property p_multi_no_dim;
        chan_count_i >= 2'h2 && $past(chan_count_i) >= 2'h2 |-> !dim_tx_o;
    endproperty
    a_multi_no_dim: assert property (p_multi_no_dim) else $error("dim telegram");
    property p_zero_follow;
        (ch1_o == 8'h00)[*4] |-> ch2_o == 8'h00 && ch3_o == 8'h00;
    endproperty
    a_zero_follow: assert property (p_zero_follow) else $error("derived not off");
    property p_single_chan;
        (chan_count_i <= 2'h1)[*4] |-> ch2_o == 8'h00 && ch3_o == 8'h00;
    endproperty
    a_single_chan: assert property (p_single_chan) else $error("extra channel on");
    property p_inc_low;
        (chan_count_i == 2'h3 && ofs_mode_i == OFS_INC && pct3_i < PCT_UNITY
            && $stable(ch1_o) && $stable(ofs_mode_i) && $stable(chan_count_i))[*4]
        |-> ch3_o <= ch1_o;
    endproperty
    a_inc_low: assert property (p_inc_low) else $error("low percent too high");
    property p_dim_code;
        dim_tx_o |-> dim_code_o == DIM_UP_STOP || dim_code_o == {1'b1, $past(step_width_i)};
    endproperty
    a_dim_code: assert property (p_dim_code) else $error("bad dim code");
    c_value: cover property (value_tx_o);
    c_stop: cover property (dim_tx_o && dim_code_o == DIM_UP_STOP);
    c_main: cover property ($rose(main_phase_o));
endmodule

bind light_out_stage light_out_monitor #(.LUX_W(LUX_W)) u_mon (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .chan_count_i(chan_count_i),
    .ofs_mode_i(ofs_mode_i), .pct3_i(pct3_i), .step_width_i(step_width_i),
    .start_i(start_i), .lux_i(lux_i), .setpoint_i(setpoint_i),
    .main_phase_o(main_phase_o), .switch_tx_o(switch_tx_o), .dim_tx_o(dim_tx_o),
    .dim_code_o(dim_code_o), .value_tx_o(value_tx_o), .ch1_o(ch1_o), .ch2_o(ch2_o),
    .ch3_o(ch3_o));

// file: tb/lamp_actuators.sv
// Actuator group model that counts received telegrams.
`timescale 1ns/100ps
module lamp_actuators (
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    input wire logic       switch_tx_i,
    input wire logic       dim_tx_i,
    input wire logic [3:0] dim_code_i,
    input wire logic       value_tx_i
);
    int         n_switch;
    int         n_dim;
    int         n_value;
    logic [3:0] last_code;
    // Cleared by reset, so every scenario starts counting from nothing.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            n_switch <= 0;
            n_dim <= 0;
            n_value <= 0;
            last_code <= 4'h0;
        end else begin
            n_switch <= n_switch + int'(switch_tx_i);
            n_value <= n_value + int'(value_tx_i);
            if (dim_tx_i) begin
                n_dim <= n_dim + 1;
                last_code <= dim_code_i;
            end
        end
    end
endmodule

// file: tb/light_control_channel_offsets_tb_top.sv
// Self-checking bench for the light controller output stage.
`timescale 1ns/100ps
module light_control_channel_offsets_tb_top;
    import light_ctrl_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        start = 1'b0;
    logic        rep_en = 1'b1;
    logic [1:0]  cnt = 2'h3;
    ofs_mode_t   om = OFS_FIXED;
    su_mode_t    sm = SU_ABSOLUTE;
    logic [7:0]  o2 = 8'h32, o3 = 8'hCE, p2 = 8'h96, p3 = 8'h32, sv = 8'h5A, c1m = 8'h00;
    logic [7:0]  sy = SYNC_DEFAULT;
    logic [6:0]  hy = HYST_DEFAULT;
    logic [2:0]  stw = 3'h5;
    logic [5:0]  rs = 6'h00, ws = 6'h01;
    logic [3:0]  rt = 4'h1;
    logic [15:0] lux = 16'h01F4, sp = 16'h03E8, rng = 16'h03E8;
    logic [7:0]  ch1, ch2, ch3;
    logic [3:0]  code;
    logic        mp, sw, dm, vt;
    int          n_mismatch = 0;
    int          checks = 0;

    initial forever #50 clk = ~clk;

    light_out_stage #(.LUX_W(16)) u_dut (
        .sys_clk_i(clk), .nrst_i(nrst), .chan_count_i(cnt), .ofs_mode_i(om),
        .ofs2_i(o2), .ofs3_i(o3), .pct2_i(p2), .pct3_i(p3), .sync2_i(sy), .sync3_i(sy),
        .hyst_i(hy), .su_mode_i(sm), .step_width_i(stw), .rep_en_i(rep_en),
        .rep_sec_i(rs), .rep_tenth_i(rt), .wait_sec_i(ws), .su_value_i(sv),
        .lux_range_i(rng), .start_i(start), .lux_i(lux), .setpoint_i(sp),
        .ch1_main_i(c1m), .main_phase_o(mp), .switch_tx_o(sw), .dim_tx_o(dm),
        .dim_code_o(code), .value_tx_o(vt), .ch1_o(ch1), .ch2_o(ch2), .ch3_o(ch3));

    lamp_actuators u_act (
        .sys_clk_i(clk), .nrst_i(nrst), .switch_tx_i(sw), .dim_tx_i(dm),
        .dim_code_i(code), .value_tx_i(vt));

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A wait that used up its bound ends the run at once.
    task automatic limit(input bit hit);
        if (hit) begin
            $display("CHECK FAILED wait bound expected 0 seen 1");
            n_mismatch++;
            finish_test();
        end
    endtask

    task automatic restart(input logic [15:0] l);
        @(posedge clk);
        nrst <= 1'b0;
        start <= 1'b0;
        lux <= l;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        start <= 1'b1;
    endtask

    task automatic su(input su_mode_t m, input logic [1:0] c, input logic [7:0] e_sw,
                      input logic [7:0] e_dm, input logic [7:0] e_vt, input logic [7:0] e1);
        @(posedge clk);
        sm <= m;
        cnt <= c;
        restart(16'h01F4);
        repeat (6) @(posedge clk);
        cmp("switch telegrams", e_sw, 8'(u_act.n_switch));
        cmp("dim telegrams", e_dm, 8'(u_act.n_dim));
        cmp("value telegrams", e_vt, 8'(u_act.n_value));
        cmp("main phase wait", 8'h00, {7'h00, mp});
        if (e_vt == 8'h01) cmp("startup ch1", e1, ch1);
        $display("Startup mode %0d with %0d channels done", m, c);
    endtask

    task automatic chk(input logic [7:0] c1, input logic [7:0] e2, input logic [7:0] e3);
        @(posedge clk);
        c1m <= c1;
        repeat (5) @(posedge clk);
        cmp("ch1", c1, ch1);
        cmp("ch2", e2, ch2);
        cmp("ch3", e3, ch3);
    endtask

    task automatic dim_stop();
        int i;
        su(SU_RELATIVE, 2'h1, 8'h00, 8'h01, 8'h00, 8'h00);
        cmp("dim up code", {1'b1, stw}, u_act.last_code);
        lux <= 16'h03E8;
        for (i = 0; i < 20 && u_act.n_dim < 2; i++) @(posedge clk);
        limit(i == 20);
        cmp("stop code", DIM_UP_STOP, u_act.last_code);
        $display("Relative dim stop test done");
    endtask

    task automatic main_phase();
        int i;
        @(posedge clk);
        cnt <= 2'h3;
        restart(16'h03E8);
        for (i = 0; i < 10 && mp !== 1'b1; i++) @(posedge clk);
        limit(i == 10);
        cmp("bright telegrams", 8'h00, 8'(u_act.n_value + u_act.n_dim + u_act.n_switch));
        chk(8'h64, 8'h96, 8'h32);
        chk(8'h3C, 8'h6E, 8'h0A);
        chk(8'h28, 8'h5A, 8'h00);
        chk(8'h3C, 8'h6E, 8'h00);
        chk(8'h47, 8'h79, 8'h15);
        chk(8'hFA, 8'hFF, 8'hC8);
        chk(8'h00, 8'h00, 8'h00);
        om <= OFS_DEC;
        chk(8'h01, 8'h33, 8'h00);
        chk(8'hC8, 8'hC8, 8'hC8);
        chk(8'hFF, 8'hFF, 8'hFF);
        om <= OFS_INC;
        chk(8'h64, 8'h96, 8'h32);
        chk(8'hC8, 8'hFF, 8'h64);
        cnt <= 2'h2;
        chk(8'h64, 8'h96, 8'h00);
        cnt <= 2'h1;
        chk(8'h64, 8'h00, 8'h00);
        $display("Main phase channel test done");
    endtask

    initial begin
        main_phase();
        su(SU_SWITCH, 2'h1, 8'h01, 8'h00, 8'h00, 8'h00);
        su(SU_SWITCH, 2'h3, 8'h00, 8'h00, 8'h01, 8'h5A);
        su(SU_RELATIVE, 2'h3, 8'h00, 8'h00, 8'h01, 8'h5A);
        su(SU_ABSOLUTE, 2'h1, 8'h00, 8'h00, 8'h01, 8'h5A);
        su(SU_ADAPTIVE, 2'h1, 8'h00, 8'h00, 8'h01, 8'h7F);
        dim_stop();
        finish_test();
    end
endmodule
